// ### smil_pkg.sv
package smil_pkg;
    // ==============================================================
    // Register location and layout.
    localparam logic [7:0] SMIL_CTRL_ADDR = 8'hDF;
    localparam logic [7:0] SMIL_CTRL_RESET = 8'hDE;
    localparam int SMIL_BIT_RSVD7 = 7;
    localparam int SMIL_BIT_DIG_OK = 6;
    localparam int SMIL_BIT_FLAG = 5;
    localparam int SMIL_BIT_TRIP_HI = 4;
    localparam int SMIL_BIT_TRIP_LO = 3;
    localparam int SMIL_BIT_RSVD2 = 2;
    localparam int SMIL_BIT_RSVD1 = 1;
    localparam int SMIL_BIT_ON = 0;

    // ==============================================================
    // Trip point codes.
    localparam logic [1:0] SMIL_TRIP_308 = 2'h1;
    localparam logic [1:0] SMIL_TRIP_293 = 2'h2;

    // ==============================================================
    // Timing.
    localparam int SMIL_HOLDOFF_MS = 250;
    localparam int SMIL_CLK_PERIOD_NS = 100;
    localparam int SMIL_HOLDOFF_CYCLES = SMIL_HOLDOFF_MS * 1000000 / SMIL_CLK_PERIOD_NS;
    localparam int SMIL_GLITCH_CYCLES = 4;
endpackage : smil_pkg

// ### smil_glitch_filter.sv
`timescale 1ns/100ps
`default_nettype none
module smil_glitch_filter
    import smil_pkg::*;
#(
    parameter int GLITCH_CYCLES = SMIL_GLITCH_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic raw_in,
    output logic sync_level_out,
    output logic filt_level_out
);
    localparam int CW = $clog2(GLITCH_CYCLES) + 1;

    typedef struct packed {
        logic [2:0] sync;
        logic [CW-1:0] cnt;
        logic filt;
    } smil_flt_state_t;

    smil_flt_state_t st_r;
    smil_flt_state_t st_nxt;

    // ==============================================================
    // A level change is accepted only after the two late sync stages
    // have agreed for GLITCH_CYCLES samples; shorter dips vanish.
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[1:0], raw_in};
        if ((st_r.sync[1] != st_r.sync[2]) || (st_r.sync[2] == st_r.filt)) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == CW'(GLITCH_CYCLES - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.filt = st_r.sync[2];
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    // Supplies are presumed good out of reset.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '{sync: 3'h7, cnt: '0, filt: 1'b1};
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    assign sync_level_out = st_r.sync[2];
    assign filt_level_out = st_r.filt;

    a_filter_stable: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
        $changed(st_r.filt) |-> $past(st_r.cnt) == CW'(GLITCH_CYCLES - 1))
        else $error("Filtered level changed before the glitch count ran out.");
endmodule : smil_glitch_filter
`default_nettype wire

// ### smil_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Bit 6 reads back the live digital-supply comparator level and cannot be written.
// - The low-supply flag in bit 5 is set whenever either supply comparator reads low while bit 0 is 1.
// - Once both comparators are high and stay high while bit 0 is 1, a 250 ms hold-off runs and clears the flag.
// - Software may write the flag, but a clearing write is ignored while bit 0 is 1 and a comparator is low.
// - Bits 4:3 pick the digital trip point, 00 being reserved and 01 selecting 3.08 V.
// - The flag reaches the core interrupt only while the monitor interrupt enable is set.
// - Short glitches on the comparator outputs are filtered out before they reach the flag; bit 6 reads the unfiltered level.
// - Bit 7 is reserved, the register resets to DEH and is accessed only as a byte.
// - Bit 0 switches supply monitoring on when 1 and off when 0.
module smil_top
    import smil_pkg::*;
#(
    parameter int HOLDOFF_CYCLES = SMIL_HOLDOFF_CYCLES,
    parameter int GLITCH_CYCLES = SMIL_GLITCH_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic digital_supply_ok_in,
    input wire logic analog_supply_ok_in,
    input wire logic monitor_irq_enable_in,
    output logic supply_irq_out,
    output logic monitor_on_out,
    output logic [1:0] trip_select_out
);
    localparam int CNT_W = $clog2(HOLDOFF_CYCLES) + 1;

    typedef enum logic [2:0] {
        SMIL_ST_OK = 3'h1,
        SMIL_ST_LOW = 3'h2,
        SMIL_ST_HOLD = 3'h4
    } smil_mon_t;

    typedef struct packed {
        smil_mon_t mon;
        logic [CNT_W-1:0] cnt;
        logic flag;
        logic [1:0] trip;
        logic [1:0] trip_eff;
        logic on;
        logic [7:0] rdata;
    } smil_state_t;

    smil_state_t st_r;
    smil_state_t st_nxt;

    logic dig_sync;
    logic dig_ok;
    logic ana_ok;
    logic low;
    logic wr_hit;
    logic rd_hit;
    logic expire;

    // ==============================================================
    // Comparator conditioning.
    smil_glitch_filter #(.GLITCH_CYCLES(GLITCH_CYCLES)) u_dig_flt (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .raw_in(digital_supply_ok_in),
        .sync_level_out(dig_sync),
        .filt_level_out(dig_ok)
    );

    smil_glitch_filter #(.GLITCH_CYCLES(GLITCH_CYCLES)) u_ana_flt (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .raw_in(analog_supply_ok_in),
        .sync_level_out(),
        .filt_level_out(ana_ok)
    );

    // ==============================================================
    // Decode and the low condition, gated by the enable bit.
    assign wr_hit = sfr_wr_in && (sfr_addr_in == SMIL_CTRL_ADDR);
    assign rd_hit = sfr_rd_in && (sfr_addr_in == SMIL_CTRL_ADDR);
    assign low = st_r.on && !(dig_ok && ana_ok);
    assign expire = (st_r.mon == SMIL_ST_HOLD) && (st_r.cnt == CNT_W'(HOLDOFF_CYCLES - 1));

    // ==============================================================
    // Next-state logic for the register, hold-off machine and read data.
    always_comb begin
        st_nxt = st_r;
        // The control fields; reserved bits hold no storage.
        if (wr_hit) begin
            st_nxt.on = sfr_wdata_in[SMIL_BIT_ON];
            st_nxt.trip = sfr_wdata_in[SMIL_BIT_TRIP_HI:SMIL_BIT_TRIP_LO];
        end
        // Reserved codes keep the last legal threshold so the comparator never floats.
        if ((st_nxt.trip == SMIL_TRIP_308) || (st_nxt.trip == SMIL_TRIP_293)) begin
            st_nxt.trip_eff = st_nxt.trip;
        end
        // Hold-off sequencing; a disabled monitor parks idle.
        if (!st_r.on) begin
            st_nxt.mon = SMIL_ST_OK;
            st_nxt.cnt = '0;
        end else begin
            case (st_r.mon)
                SMIL_ST_OK: begin
                    if (low) begin
                        st_nxt.mon = SMIL_ST_LOW;
                    end
                end
                SMIL_ST_LOW: begin
                    st_nxt.cnt = '0;
                    if (!low) begin
                        st_nxt.mon = SMIL_ST_HOLD;
                    end
                end
                SMIL_ST_HOLD: begin
                    if (low) begin
                        st_nxt.mon = SMIL_ST_LOW;
                    end else if (expire) begin
                        st_nxt.mon = SMIL_ST_OK;
                    end else begin
                        st_nxt.cnt = st_r.cnt + CNT_W'(1);
                    end
                end
                default: begin
                    st_nxt.mon = SMIL_ST_OK;
                    st_nxt.cnt = '0;
                end
            endcase
        end
        // Flag: the low condition beats every clear, so no event is lost.
        if (low) begin
            st_nxt.flag = 1'b1;
        end else if (expire) begin
            st_nxt.flag = 1'b0;
        end else if (wr_hit) begin
            st_nxt.flag = sfr_wdata_in[SMIL_BIT_FLAG];
        end
        // Read data is captured one edge after the strobe; bit 6 is live.
        st_nxt.rdata = 8'h00;
        if (rd_hit) begin
            st_nxt.rdata[SMIL_BIT_RSVD7] = SMIL_CTRL_RESET[SMIL_BIT_RSVD7];
            st_nxt.rdata[SMIL_BIT_DIG_OK] = dig_sync;
            st_nxt.rdata[SMIL_BIT_FLAG] = st_r.flag;
            st_nxt.rdata[SMIL_BIT_TRIP_HI:SMIL_BIT_TRIP_LO] = st_r.trip;
            st_nxt.rdata[SMIL_BIT_RSVD2] = SMIL_CTRL_RESET[SMIL_BIT_RSVD2];
            st_nxt.rdata[SMIL_BIT_RSVD1] = SMIL_CTRL_RESET[SMIL_BIT_RSVD1];
            st_nxt.rdata[SMIL_BIT_ON] = st_r.on;
        end
    end

    // ==============================================================
    // State register; the clock enable freezes everything.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '{mon: SMIL_ST_OK, cnt: '0,
                flag: SMIL_CTRL_RESET[SMIL_BIT_FLAG],
                trip: SMIL_CTRL_RESET[SMIL_BIT_TRIP_HI:SMIL_BIT_TRIP_LO],
                trip_eff: SMIL_TRIP_308,
                on: SMIL_CTRL_RESET[SMIL_BIT_ON],
                rdata: 8'h00};
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // ==============================================================
    // Outputs.
    assign sfr_rdata_out = st_r.rdata;
    assign supply_irq_out = st_r.flag && monitor_irq_enable_in;
    assign monitor_on_out = st_r.on;
    assign trip_select_out = st_r.trip_eff;

    // ==============================================================
    // Checks.
    default clocking smil_cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in || !clk_en_in);

    sequence s_recovered;
        (st_r.mon == SMIL_ST_HOLD) && (st_r.cnt == CNT_W'(HOLDOFF_CYCLES - 1)) && !low;
    endsequence

    a_cmp_bit_live: assert property (rd_hit |=> sfr_rdata_out[SMIL_BIT_DIG_OK] == $past(dig_sync))
        else $error("Comparator bit does not show the synchronised level.");
    a_flag_sets_low: assert property (low |=> st_r.flag)
        else $error("Flag not set while a supply is low.");
    a_holdoff_clear: assert property (s_recovered |=> !st_r.flag && st_r.mon == SMIL_ST_OK)
        else $error("Flag not cleared when the hold-off expired.");
    a_no_early_clear: assert property ($fell(st_r.flag) |-> $past(expire)
        || ($past(wr_hit) && !$past(sfr_wdata_in[SMIL_BIT_FLAG])))
        else $error("Flag cleared without expiry or a software write.");
    a_clear_blocked: assert property (wr_hit && !sfr_wdata_in[SMIL_BIT_FLAG] && low
        |=> st_r.flag)
        else $error("Software cleared the flag while a supply was low.");
    a_trip_field: assert property (wr_hit |=> st_r.trip == $past(sfr_wdata_in[4:3]))
        else $error("Trip field did not take the written code.");
    a_irq_gate: assert property (supply_irq_out |-> st_r.flag && monitor_irq_enable_in)
        else $error("Interrupt raised without flag and enable.");
    a_reserved_read: assert property (rd_hit |=> sfr_rdata_out[7] && sfr_rdata_out[2]
        && sfr_rdata_out[1])
        else $error("Reserved bits read wrong.");
    a_on_bit: assert property (wr_hit |=> monitor_on_out == $past(sfr_wdata_in[0]))
        else $error("Enable bit did not follow the write.");
    a_off_no_set: assert property (!st_r.on && !st_r.flag && !wr_hit |=> !st_r.flag)
        else $error("Flag set while monitoring was off.");
    // A fresh dip during the hold-off must restart the wait, not let it run on.
    a_holdoff_restart: assert property (st_r.mon == SMIL_ST_HOLD && low
        |=> st_r.mon == SMIL_ST_LOW)
        else $error("Hold-off did not restart on a new low.");
    // The flag is sticky: only expiry or a software write may take it down.
    a_flag_sticky: assert property (st_r.flag && !expire && !wr_hit |=> st_r.flag)
        else $error("Flag dropped without expiry or a write.");
    // A reserved code must leave the comparator on its last legal threshold.
    a_trip_kept: assert property (wr_hit && (sfr_wdata_in[4:3] == 2'h0
        || sfr_wdata_in[4:3] == 2'h3) |=> trip_select_out == $past(trip_select_out))
        else $error("Reserved trip code reached the comparator.");
endmodule : smil_top
`default_nettype wire

// ### smil_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==============================================================
// Supply comparator model
// The digital comparator trips against the threshold chosen by the
// block's trip select output. Supply levels are given in millivolts.
module smil_supply_model
    import smil_pkg::*;
(
    input wire logic [1:0] trip_select_in,
    input wire logic [11:0] dig_mv_in,
    input wire logic ana_good_in,
    output logic digital_supply_ok_out,
    output logic analog_supply_ok_out
);
    // Any code other than 2.93 V is treated as 3.08 V, the safer and higher point.
    always_comb begin
        digital_supply_ok_out = (trip_select_in == SMIL_TRIP_293) ? (dig_mv_in > 12'hB72) :
            (dig_mv_in > 12'hC08);
        analog_supply_ok_out = ana_good_in;
    end
endmodule : smil_supply_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ==============================================================
// Testbench
module testbench;
    import smil_pkg::*;
    localparam int HOLD = 20;
    logic clk_in, sys_rst_in, sfr_wr_in, sfr_rd_in, irq_en, ana_good, clk_en;
    logic [7:0] sfr_addr_in, sfr_wdata_in, rd_val;
    logic [11:0] dig_mv;
    wire logic [7:0] rdata;
    wire logic dig_ok, ana_ok, irq, mon_on;
    wire logic [1:0] trip;
    int errors = 0;
    int n_compared = 0;
    // A short hold-off keeps the run brief; expectations use HOLD.
    smil_top #(.HOLDOFF_CYCLES(HOLD), .GLITCH_CYCLES(SMIL_GLITCH_CYCLES)) u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(rdata),
        .digital_supply_ok_in(dig_ok), .analog_supply_ok_in(ana_ok),
        .monitor_irq_enable_in(irq_en), .supply_irq_out(irq),
        .monitor_on_out(mon_on), .trip_select_out(trip));
    smil_supply_model u_model (.trip_select_in(trip), .dig_mv_in(dig_mv),
        .ana_good_in(ana_good), .digital_supply_ok_out(dig_ok),
        .analog_supply_ok_out(ana_ok));
    // Clock at 10 MHz.
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic close_out();
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // Every drive happens 1 ns after a rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        step(1);
        sfr_wr_in = 1'b0;
    endtask : wr
    // Read data stands for the one cycle after the taking edge.
    task automatic rd(input logic [7:0] a);
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        step(1);
        sfr_rd_in = 1'b0;
        rd_val = rdata;
    endtask : rd
    function automatic logic [7:0] regv(input logic d, input logic f, input logic [1:0] t,
        input logic o);
        return {1'b1, d, f, t, 2'b11, o};
    endfunction : regv
    task automatic t_modes();
        logic [7:0] wv [5];
        logic [1:0] exp_t;
        wv = '{8'h00, 8'h09, 8'h11, 8'h19, 8'hC6};
        exp_t = SMIL_TRIP_308;
        foreach (wv[i]) begin
            wr(SMIL_CTRL_ADDR, wv[i]);
            if (wv[i][4:3] == SMIL_TRIP_308 || wv[i][4:3] == SMIL_TRIP_293) exp_t = wv[i][4:3];
            rd(SMIL_CTRL_ADDR);
            chk(rd_val, regv(1'b1, 1'b0, wv[i][4:3], wv[i][0]));
            chk({6'h00, trip}, {6'h00, exp_t});
            chk({7'h00, mon_on}, {7'h00, wv[i][0]});
        end
    endtask : t_modes
    task automatic t_dip();
        wr(SMIL_CTRL_ADDR, 8'h09);
        dig_mv = 12'hBB8;
        step(12);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b0, 1'b1, 2'h1, 1'b1));
        chk({7'h00, irq}, 8'h00);
        irq_en = 1'b1;
        step(1);
        chk({7'h00, irq}, 8'h01);
        wr(SMIL_CTRL_ADDR, 8'h09);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b0, 1'b1, 2'h1, 1'b1));
        // Lowering the trip point makes the same supply good again.
        wr(SMIL_CTRL_ADDR, 8'h11);
        step(12);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b1, 1'b1, 2'h2, 1'b1));
        step(HOLD + 10);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b1, 1'b0, 2'h2, 1'b1));
        chk({7'h00, irq}, 8'h00);
    endtask : t_dip
    task automatic t_analog();
        ana_good = 1'b0;
        step(2);
        ana_good = 1'b1;
        step(15);
        chk({7'h00, irq}, 8'h00);
        ana_good = 1'b0;
        step(12);
        chk({7'h00, irq}, 8'h01);
        ana_good = 1'b1;
        step(12);
        // A second dip inside the hold-off must restart it from the beginning.
        ana_good = 1'b0;
        step(12);
        ana_good = 1'b1;
        step(HOLD);
        chk({7'h00, irq}, 8'h01);
        step(20);
        chk({7'h00, irq}, 8'h00);
    endtask : t_analog
    task automatic t_off();
        wr(SMIL_CTRL_ADDR, 8'h10);
        ana_good = 1'b0;
        step(15);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b1, 1'b0, 2'h2, 1'b0));
        ana_good = 1'b1;
        step(12);
        wr(SMIL_CTRL_ADDR, 8'h30);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b1, 1'b1, 2'h2, 1'b0));
        wr(SMIL_CTRL_ADDR, 8'h10);
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b1, 1'b0, 2'h2, 1'b0));
    endtask : t_off
    // With the clock enable low a write must leave every field untouched.
    task automatic t_freeze();
        clk_en = 1'b0;
        wr(SMIL_CTRL_ADDR, 8'h39);
        clk_en = 1'b1;
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, regv(1'b1, 1'b0, 2'h2, 1'b0));
        chk({7'h00, mon_on}, 8'h00);
    endtask : t_freeze
    task automatic t_reset();
        rd(SMIL_CTRL_ADDR);
        chk(rd_val, SMIL_CTRL_RESET);
        // Let an edge pass so the read strobe is not driven twice in one step.
        step(1);
        rd(8'hDE);
        chk(rd_val, 8'h00);
        chk({6'h00, trip}, {6'h00, SMIL_TRIP_308});
    endtask : t_reset
    // Watchdog: the whole sequence needs well under 1,000 cycles.
    initial begin
        #300000;
        errors++;
        close_out();
    end
    // Main sequence, ending with a reset in mid-run.
    initial begin
        sys_rst_in = 1'b1;
        {sfr_wr_in, sfr_rd_in, irq_en} = 3'h0;
        clk_en = 1'b1;
        ana_good = 1'b1;
        sfr_addr_in = 8'h00;
        sfr_wdata_in = 8'h00;
        dig_mv = 12'hCE4;
        step(8);
        sys_rst_in = 1'b0;
        t_reset();
        t_modes();
        t_dip();
        t_analog();
        t_off();
        t_freeze();
        wr(SMIL_CTRL_ADDR, 8'h39);
        sys_rst_in = 1'b1;
        step(2);
        sys_rst_in = 1'b0;
        t_reset();
        close_out();
    end
endmodule : testbench
`default_nettype wire
